// ==== shared/bus_release_regs.svh ====
// Timing counts and reset values for the bus-release control.
`ifndef BUS_RELEASE_REGS_SVH
`define BUS_RELEASE_REGS_SVH
`define MCLK_PERIOD_NS          50
`define CLOCK_HIGH_WIDTH_LIMIT_NS 4500
`define STALL_COUNT_WIDTH       8
`define ADDRESS_RESET_VALUE     16'hFFFE
`define DATA_RESET_VALUE        8'h00
`define PIN_SYNC_WIDTH          7
`endif

// ==== shared/bus_release_pkg.sv ====
// Types shared by the bus-release control design.
package bus_release_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_TRISTATE,
    ST_DEAD,
    ST_HALTED,
    ST_WAITING
  } bus_state_type;
endpackage

// ==== core/sync_cell.sv ====
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ns
`default_nettype none
module sync_cell #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] reset_value,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  initial begin
    if (WIDTH < 1) begin
      $error("sync_cell width must be at least one");
    end
  end

  // The reset value is a constant tie at every instance of this cell.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_q <= reset_value;
      sync_q <= reset_value;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ==== core/cpu_bus_release_control.sv ====
// Bus-release control of the processor: three-state, halt, wait and data drive shaping.
// Functional notes
// - Three-state request floats address and read/write.
// - Three-state request forces strobe and released flag low.
// - After release, redrive, dead cycle, then resume.
// - Released flag high only when halted or waiting.
// - Released flag means drivers off, outputs inactive.
// - Unmasked or nonmaskable interrupt ends wait.
// - Three-state request keeps released flag low.
// - Data drivers follow data drive enable.
// - Read cycles keep data drivers off.
// - Sixteen-bit address, eight-bit three-state data.
// - Halt finishes current instruction before stopping.
`timescale 1ns/1ns
`default_nettype none
`include "bus_release_regs.svh"
module cpu_bus_release_control
  import bus_release_pkg::*;
#(
  parameter int ADDR_WIDTH = 16,
  parameter int DATA_WIDTH = 8
) (
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  phase_one_clock,
  input  wire logic                  phase_two_clock,
  input  wire logic                  three_state_request,
  input  wire logic                  data_drive_enable,
  input  wire logic                  halt_n,
  input  wire logic                  maskable_interrupt_request_n,
  input  wire logic                  nonmaskable_interrupt_n,
  input  wire logic [DATA_WIDTH-1:0] data_in,
  input  wire logic                  interrupt_mask,
  input  wire logic [ADDR_WIDTH-1:0] core_address,
  input  wire logic                  core_read_write,
  input  wire logic                  core_address_valid,
  input  wire logic [DATA_WIDTH-1:0] core_write_data,
  input  wire logic                  core_instruction_last,
  input  wire logic                  core_wait_for_interrupt_op,
  output logic      [ADDR_WIDTH-1:0] address_out,
  output logic                       address_oe,
  output logic                       read_write_out,
  output logic                       read_write_oe,
  output logic      [DATA_WIDTH-1:0] data_out,
  output logic                       data_oe,
  output logic                       valid_address_strobe,
  output logic                       bus_released_flag,
  output logic      [DATA_WIDTH-1:0] core_read_data,
  output logic                       core_advance,
  output logic                       dead_cycle,
  output logic                       clock_stall_overrun
);
  localparam int STALL_LIMIT_CYCLES = `CLOCK_HIGH_WIDTH_LIMIT_NS / `MCLK_PERIOD_NS;
  localparam logic [`STALL_COUNT_WIDTH-1:0] STALL_LIMIT = STALL_LIMIT_CYCLES[`STALL_COUNT_WIDTH-1:0];

  initial begin
    if (ADDR_WIDTH != 16 || DATA_WIDTH != 8 || STALL_LIMIT_CYCLES >= (1 << `STALL_COUNT_WIDTH)) begin
      $error("bus widths must be 16 address and 8 data bits");
    end
  end

  logic [`PIN_SYNC_WIDTH-1:0] pins_raw;
  logic [`PIN_SYNC_WIDTH-1:0] pins_sync;
  logic [DATA_WIDTH-1:0]      data_sync;
  logic                       phi1_s;
  logic                       phi2_s;
  logic                       float_req_s;
  logic                       dde_s;
  logic                       halt_s_n;
  logic                       irq_s_n;
  logic                       nmi_s_n;
  logic                       phi2_prev_q;
  logic                       cycle_end;
  logic                       wake_request;
  bus_state_type              state_q;
  bus_state_type              state_d;
  logic [ADDR_WIDTH-1:0]      address_q;
  logic                       read_write_q;
  logic                       address_valid_q;
  logic [DATA_WIDTH-1:0]      data_q;
  logic [DATA_WIDTH-1:0]      read_data_q;
  logic [`STALL_COUNT_WIDTH-1:0] stall_count_q;
  logic                       overrun_q;
  logic                       on_bus;
  logic                       stopped;

  assign pins_raw = {phase_one_clock, phase_two_clock, three_state_request, data_drive_enable,
                     halt_n, maskable_interrupt_request_n, nonmaskable_interrupt_n};

  sync_cell #(.WIDTH(`PIN_SYNC_WIDTH)) pin_sync (
    .mclk        (mclk),
    .resetn      (resetn),
    .pin_in      (pins_raw),
    .reset_value (7'h07),
    .sync_out    (pins_sync)
  );

  sync_cell #(.WIDTH(DATA_WIDTH)) data_pin_sync (
    .mclk        (mclk),
    .resetn      (resetn),
    .pin_in      (data_in),
    .reset_value (`DATA_RESET_VALUE),
    .sync_out    (data_sync)
  );

  assign phi1_s   = pins_sync[6];
  assign phi2_s   = pins_sync[5];
  assign float_req_s = pins_sync[4];
  assign dde_s    = pins_sync[3];
  assign halt_s_n = pins_sync[2];
  assign irq_s_n  = pins_sync[1];
  assign nmi_s_n  = pins_sync[0];

  // A machine cycle ends at the falling edge of phase two; a stalled clock yields none.
  assign cycle_end    = phi2_prev_q && !phi2_s;
  assign wake_request = !nmi_s_n || (!irq_s_n && !interrupt_mask);
  assign stopped      = (state_q == ST_HALTED) || (state_q == ST_WAITING);
  assign on_bus       = !float_req_s && !stopped && (state_q != ST_TRISTATE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (float_req_s) begin
          state_d = ST_TRISTATE;
        end else if (cycle_end && core_wait_for_interrupt_op) begin
          state_d = ST_WAITING;
        end else if (cycle_end && core_instruction_last && !halt_s_n) begin
          state_d = ST_HALTED;
        end
      end
      ST_TRISTATE: begin
        if (!float_req_s) begin
          state_d = ST_DEAD;
        end
      end
      ST_DEAD: begin
        if (float_req_s) begin
          state_d = ST_TRISTATE;
        end else if (cycle_end) begin
          state_d = ST_RUN;
        end
      end
      ST_HALTED: begin
        if (halt_s_n && !float_req_s) begin
          state_d = ST_RUN;
        end
      end
      ST_WAITING: begin
        if (wake_request && !float_req_s) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // The core is stepped only in running cycles, so a stall freezes its state as it was.
  assign core_advance = (state_q == ST_RUN) && !float_req_s && cycle_end;
  assign dead_cycle   = (state_q == ST_DEAD);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q     <= ST_RUN;
      phi2_prev_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      phi2_prev_q <= phi2_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      address_q       <= `ADDRESS_RESET_VALUE;
      read_write_q    <= 1'b1;
      address_valid_q <= 1'b0;
      data_q          <= `DATA_RESET_VALUE;
    end else if (state_q == ST_RUN && !float_req_s) begin
      address_q       <= core_address;
      read_write_q    <= core_read_write;
      address_valid_q <= core_address_valid;
      data_q          <= core_write_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      read_data_q <= `DATA_RESET_VALUE;
    end else if (read_write_q && dde_s) begin
      read_data_q <= data_sync;
    end
  end

  // Phase one held high beyond the limit corrupts the dynamic state; this flags it.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stall_count_q <= '0;
      overrun_q     <= 1'b0;
    end else if (!phi1_s) begin
      stall_count_q <= '0;
      overrun_q     <= 1'b0;
    end else if (stall_count_q != STALL_LIMIT) begin
      stall_count_q <= stall_count_q + 1'b1;
    end else begin
      overrun_q <= 1'b1;
    end
  end

  assign address_out          = address_q;
  assign read_write_out       = read_write_q;
  assign data_out             = data_q;
  assign core_read_data       = read_data_q;
  assign clock_stall_overrun  = overrun_q;
  assign address_oe           = on_bus;
  assign read_write_oe        = on_bus;
  assign valid_address_strobe = on_bus && (state_q == ST_RUN) && address_valid_q;
  assign bus_released_flag    = stopped && !float_req_s;
  assign data_oe              = on_bus && dde_s && !read_write_q;

  property p_float_on_request;
    @(posedge mclk) disable iff (!resetn) float_req_s |-> !address_oe && !read_write_oe && !data_oe;
  endproperty
  a_float_on_request: assert property (p_float_on_request) else $error("bus driven during three-state");

  property p_strobe_low;
    @(posedge mclk) disable iff (!resetn) float_req_s |-> !valid_address_strobe && !bus_released_flag;
  endproperty
  a_strobe_low: assert property (p_strobe_low) else $error("strobe or flag high during three-state");

  property p_dead_then_run;
    @(posedge mclk) disable iff (!resetn)
      (state_q == ST_TRISTATE) && !float_req_s |=> dead_cycle && address_oe && !valid_address_strobe && !core_advance;
  endproperty
  a_dead_then_run: assert property (p_dead_then_run) else $error("no dead cycle after release");

  property p_resume;
    @(posedge mclk) disable iff (!resetn) dead_cycle && cycle_end && !float_req_s |=> state_q == ST_RUN;
  endproperty
  a_resume: assert property (p_resume) else $error("execution not resumed after dead cycle");

  property p_flag_meaning;
    @(posedge mclk) disable iff (!resetn)
      (state_q == ST_RUN) || (state_q == ST_DEAD) || (state_q == ST_TRISTATE) || float_req_s |-> !bus_released_flag;
  endproperty
  a_flag_meaning: assert property (p_flag_meaning) else $error("released flag high while running");

  property p_flag_raised;
    @(posedge mclk) disable iff (!resetn) (state_q == ST_HALTED) && !float_req_s |-> bus_released_flag;
  endproperty
  a_flag_raised: assert property (p_flag_raised) else $error("released flag low while halted");

  property p_released_quiet;
    @(posedge mclk) disable iff (!resetn)
      bus_released_flag |-> !address_oe && !read_write_oe && !data_oe && !valid_address_strobe && !core_advance;
  endproperty
  a_released_quiet: assert property (p_released_quiet) else $error("output active while released");

  property p_wake;
    @(posedge mclk) disable iff (!resetn) (state_q == ST_WAITING) && wake_request && !float_req_s |=> state_q == ST_RUN;
  endproperty
  a_wake: assert property (p_wake) else $error("wait not left on interrupt");

  property p_stay_waiting;
    @(posedge mclk) disable iff (!resetn) (state_q == ST_WAITING) && !wake_request |=> state_q == ST_WAITING;
  endproperty
  a_stay_waiting: assert property (p_stay_waiting) else $error("wait left without interrupt");

  property p_data_enable;
    @(posedge mclk) disable iff (!resetn) data_oe |-> dde_s && !read_write_out;
  endproperty
  a_data_enable: assert property (p_data_enable) else $error("data driven without enable or in read");

  property p_halt_boundary;
    @(posedge mclk) disable iff (!resetn)
      (state_q == ST_RUN) && !float_req_s && !core_instruction_last && !core_wait_for_interrupt_op |=> state_q != ST_HALTED;
  endproperty
  a_halt_boundary: assert property (p_halt_boundary) else $error("halted inside an instruction");

  property p_frozen;
    @(posedge mclk) disable iff (!resetn) (state_q == ST_TRISTATE) && float_req_s |=> $stable(address_q) && !core_advance;
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved while stalled");

  property p_overrun;
    @(posedge mclk) disable iff (!resetn) phi1_s && (stall_count_q == STALL_LIMIT) && $stable(phi1_s) |=> clock_stall_overrun || !phi1_s;
  endproperty
  a_overrun: assert property (p_overrun) else $error("stall overrun not flagged");
endmodule
`default_nettype wire

// ==== bench/clock_dma_partner.sv ====
// Two-phase clock source and DMA master that face the bus-release control.
`timescale 1ns/1ns
`default_nettype none
module clock_dma_partner (
  input  wire logic       mclk,
  input  wire logic       dma_go,
  input  wire logic [7:0] dma_len,
  output logic            phase_one_clock,
  output logic            phase_two_clock,
  output logic            three_state_request,
  output logic            data_drive_enable,
  output logic      [7:0] data_in,
  output logic            dma_busy
);
  logic go_q;
  task automatic step(input int n);
    repeat (n) begin
      @(posedge mclk);
      go_q = dma_go;
      #2;
      data_in = 8'($urandom);  // Nobody holds the bus, so the lines wander every cycle.
    end
  endtask
  initial begin
    {phase_one_clock, phase_two_clock, three_state_request, data_drive_enable, dma_busy, go_q} = 6'h00;
    data_in = 8'h00;
    forever begin
      phase_one_clock = 1'b1;
      step(9);
      if (go_q) begin
        dma_busy = 1'b1;  // Phase one stays high and phase two low all through.
        three_state_request = 1'b1;
        step(int'(dma_len));  // Transfers go here; overlong stalls only when commanded.
        three_state_request = 1'b0;
        step(1);
        dma_busy = 1'b0;
      end
      phase_one_clock = 1'b0;
      step(1);
      phase_two_clock = 1'b1;
      data_drive_enable = 1'b1;
      step(9);
      phase_two_clock = 1'b0;
      data_drive_enable = 1'b0;  // Phase one high time lies inside this low span.
      step(1);
    end
  end
endmodule
`default_nettype wire

// ==== bench/cpu_bus_release_control_tb_top.sv ====
// Self-checking bench for the bus-release control.
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_release_control_tb_top;
  logic        mclk, resetn, phase_one_clock, phase_two_clock, three_state_request, data_drive_enable;
  logic        halt_n, maskable_interrupt_request_n, nonmaskable_interrupt_n, interrupt_mask, dma_go, dma_busy;
  logic        core_read_write, core_address_valid, core_instruction_last, core_wait_for_interrupt_op;
  logic        address_oe, read_write_out, read_write_oe, data_oe, valid_address_strobe, bus_released_flag;
  logic        core_advance, dead_cycle, clock_stall_overrun;
  logic [15:0] core_address, address_out, ap;
  logic [7:0]  data_in, core_write_data, data_out, core_read_data, dma_len;
  int          n_fail, checked, ts1, ts2, dd1, dd2, tsp;
  logic [15:0] ad_exp;
  logic [7:0]  wd_exp, rd_exp, di1, di2;
  logic        rw_exp, cap_run, cap_rd;
  cpu_bus_release_control u_dut (.mclk, .resetn, .phase_one_clock, .phase_two_clock, .three_state_request,
    .data_drive_enable, .halt_n, .maskable_interrupt_request_n, .nonmaskable_interrupt_n, .data_in,
    .interrupt_mask, .core_address, .core_read_write, .core_address_valid, .core_write_data,
    .core_instruction_last, .core_wait_for_interrupt_op, .address_out, .address_oe, .read_write_out,
    .read_write_oe, .data_out, .data_oe, .valid_address_strobe, .bus_released_flag, .core_read_data,
    .core_advance, .dead_cycle, .clock_stall_overrun);
  clock_dma_partner u_far (.mclk, .dma_go, .dma_len, .phase_one_clock, .phase_two_clock,
    .three_state_request, .data_drive_enable, .data_in, .dma_busy);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("mismatches %0d, comparisons %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int i;
    i = 0;
    while (s !== v && i < lim) begin
      tick(1);
      i++;
    end
    chk(s, v);
  endtask
  task automatic dma(input int len, input bit run);
    dma_len = 8'(len);
    dma_go = 1'b1;
    wait_for(dma_busy, 1'b1, 60);
    dma_go = 1'b0;
    wait_for(dma_busy, 1'b0, 200);
    chk(clock_stall_overrun, 16'(len > 80));
    if (run) begin
      wait_for(dead_cycle, 1'b1, 6);
      chk(address_oe, 1'h1);
      wait_for(dead_cycle, 1'b0, 40);
      wait_for(core_advance, 1'b1, 40);
    end
  endtask
  // Bench copy of the two-stage pin synchroniser, so pin effects are expected two edges late.
  always @(posedge mclk) begin
    ts1 <= resetn ? int'(three_state_request) : 0;
    ts2 <= resetn ? ts1 : 0;
    dd1 <= resetn ? int'(data_drive_enable) : 0;
    dd2 <= resetn ? dd1 : 0;
    di1 <= resetn ? data_in : 8'h00;
    di2 <= resetn ? di1 : 8'h00;
  end
  always @(posedge mclk) begin
    #2;
    core_address = 16'($urandom);
    core_write_data = 8'($urandom);
    {core_read_write, core_address_valid} = 2'($urandom);
  end
  always @(negedge mclk) begin
    if (resetn) begin
      if (ts2 == 1) begin
        chk({address_oe, read_write_oe}, 2'h0);
        chk({valid_address_strobe, bus_released_flag}, 2'h0);
        if (tsp == 1) chk(address_out, ap);
      end
      if (dd2 == 0) chk(data_oe, 1'h0);
      if (read_write_out === 1'b1) chk(data_oe, 1'h0);
      if (address_oe === 1'b1 && dd2 == 1 && read_write_out === 1'b0) chk(data_oe, 1'h1);
      if (bus_released_flag === 1'b1) chk({address_oe, read_write_oe, data_oe, valid_address_strobe, core_advance}, 5'h00);
      if (dead_cycle === 1'b1) chk({core_advance, valid_address_strobe}, 2'h0);
      if (cap_run) chk(address_out, ad_exp);
      if (cap_run) chk(read_write_out, rw_exp);
      if (cap_run) chk(data_out, wd_exp);
      if (cap_rd) chk(core_read_data, rd_exp);
      cap_run = address_oe === 1'b1 && dead_cycle === 1'b0;
      cap_rd = read_write_out === 1'b1 && dd2 == 1;
      ad_exp = core_address;
      rw_exp = core_read_write;
      wd_exp = core_write_data;
      rd_exp = di2;
      tsp = ts2;
      ap = address_out;
    end
  end
  initial begin
    #2_000_000;
    n_fail++;
    results();
  end
  initial begin
    {resetn, dma_go, core_wait_for_interrupt_op} = 3'h0;
    {halt_n, maskable_interrupt_request_n, nonmaskable_interrupt_n, interrupt_mask, core_instruction_last} = 5'h1f;
    {n_fail, checked, tsp} = '0;
    {cap_run, cap_rd} = 2'h0;
    dma_len = 8'h00;
    void'($urandom(54));
    tick(16);
    chk(address_out, 16'hfffe);
    chk({read_write_out, valid_address_strobe, bus_released_flag, data_oe, clock_stall_overrun}, 5'h10);
    resetn = 1'b1;
    tick(20);
    for (int i = 0; i < 4; i++) dma(10 + int'($urandom_range(50)), 1'b1);
    core_instruction_last = 1'b0;
    halt_n = 1'b0;
    tick(60);
    chk(bus_released_flag, 1'h0);
    core_instruction_last = 1'b1;
    wait_for(bus_released_flag, 1'b1, 60);
    dma(20, 1'b0);
    tick(4);
    chk(bus_released_flag, 1'h1);
    halt_n = 1'b1;
    wait_for(bus_released_flag, 1'b0, 60);
    for (int k = 0; k < 2; k++) begin
      core_wait_for_interrupt_op = 1'b1;
      wait_for(bus_released_flag, 1'b1, 60);
      core_wait_for_interrupt_op = 1'b0;
      maskable_interrupt_request_n = 1'b0;
      tick(60);
      chk(bus_released_flag, 1'h1);
      if (k == 1) interrupt_mask = 1'b0;
      else nonmaskable_interrupt_n = 1'b0;
      wait_for(bus_released_flag, 1'b0, 60);
      {maskable_interrupt_request_n, nonmaskable_interrupt_n, interrupt_mask} = 3'h7;
      tick(20);
    end
    dma(100, 1'b0);
    results();
  end
endmodule
`default_nettype wire
